// ==== fpr_fan_ctrl.v ====
/*
 * Three-channel fan PWM: rate select, temperature-to-duty slope,
 * overtemperature pin, channel 1 duty ramp, speed-input grouping,
 * with a classic Wishbone slave for its registers.
 * Assumes temperatures, limits, start points, hysteresis and minimum
 * duties come from neighbouring logic, and monitor_cycle_in pulses
 * once at the end of each monitoring cycle.
 */
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "fpr_defines.vh"

module fpr_fan_ctrl #(
    parameter RAMP_SLOT_CYCLES =
        `FPR_RAMP_FULL_MS * `FPR_CYC_PER_MS / `FPR_RAMP_COUNTS
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [31:0] wb_adr_in,
    input wire [31:0] wb_dat_in,
    input wire [3:0] wb_sel_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    output wire irq_out,
    input wire monitor_cycle_in,
    input wire [2:0] auto_mode_in,
    input wire [23:0] manual_duty_in,
    input wire [29:0] temp_in,
    input wire [23:0] crit_limit_in,
    input wire [23:0] fan_start_temp_in,
    input wire [23:0] hyst_in,
    input wire [23:0] min_duty_in,
    input wire overtemp_pin_in,
    output wire overtemp_pin_out,
    output wire overtemp_pin_oe_out,
    input wire fan_speed_input_2_in,
    input wire fan_speed_input_3_in,
    input wire fan_speed_input_4_in,
    output wire [2:0] speed_gate_out,
    output wire [2:0] speed_sample_out,
    output wire fan_drive_out_1_out,
    output wire fan_drive_out_2_out,
    output wire fan_drive_out_3_out
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    reg [7:0] cfg_q [0:2];
    reg [7:0] ramp_q;
    reg lock_q;
    reg [`FPR_NSTAT-1:0] stat_q;
    reg [`FPR_NSTAT-1:0] mask_q;
    reg [`FPR_NSTAT-1:0] stat_d;
    reg [7:0] rd_d;
    wire [7:0] idx = wb_adr_in[9:2];
    wire req = wb_cyc_in & wb_stb_in;
    wire wr_go = req & wb_ack_out & wb_we_in & wb_sel_in[0];
    wire rd_stat = req & wb_ack_out & ~wb_we_in & (idx == `FPR_IDX_STAT);
    wire [`FPR_NSTAT-1:0] evt;

    // Read mux; unmapped indices read as zero
    always @* begin
        case (idx)
            `FPR_IDX_CFG1: rd_d = cfg_q[0];
            `FPR_IDX_CFG2: rd_d = cfg_q[1];
            `FPR_IDX_CFG3: rd_d = cfg_q[2];
            `FPR_IDX_RAMP: rd_d = ramp_q;
            `FPR_IDX_CTRL: rd_d = {7'h00, lock_q};
            `FPR_IDX_STAT: rd_d = {{(8-`FPR_NSTAT){1'b0}}, stat_q};
            `FPR_IDX_MASK: rd_d = {{(8-`FPR_NSTAT){1'b0}}, mask_q};
            default: rd_d = 8'h00;
        endcase
    end

    // Read clears only the bits it returned, so an event caught between
    // data capture and ack is not lost; a same-cycle event survives
    always @* begin
        stat_d = rd_stat ? stat_q & ~wb_dat_out[`FPR_NSTAT-1:0] : stat_q;
        stat_d = stat_d | evt;
    end

    // Ack one cycle after the request, dropped the cycle after;
    // writes land on the edge where the master sees ack
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
            cfg_q[0] <= `FPR_CFG_RST;
            cfg_q[1] <= `FPR_CFG_RST;
            cfg_q[2] <= `FPR_CFG_RST;
            ramp_q <= `FPR_RAMP_RST;
            lock_q <= 1'b0;
            stat_q <= {`FPR_NSTAT{1'b0}};
            mask_q <= {`FPR_NSTAT{1'b0}};
        end else begin
            wb_ack_out <= req & ~wb_ack_out;
            if (req & ~wb_ack_out)
                wb_dat_out <= {24'h00_0000, rd_d};
            stat_q <= stat_d;
            if (wr_go) begin
                // Locked config and ramp registers drop writes silently
                if (!lock_q) begin
                    case (idx)
                        `FPR_IDX_CFG1: cfg_q[0] <= wb_dat_in[7:0];
                        `FPR_IDX_CFG2: cfg_q[1] <= wb_dat_in[7:0];
                        `FPR_IDX_CFG3: cfg_q[2] <= wb_dat_in[7:0];
                        `FPR_IDX_RAMP: ramp_q <= wb_dat_in[7:0];
                        default: ramp_q <= ramp_q;
                    endcase
                end
                // Lock only sets; reset is the one way out
                if (idx == `FPR_IDX_CTRL)
                    lock_q <= lock_q | wb_dat_in[`FPR_LOCK_BIT];
                if (idx == `FPR_IDX_MASK)
                    mask_q <= wb_dat_in[`FPR_NSTAT-1:0];
            end
        end
    end

    assign irq_out = |(stat_q & mask_q);

    // ****************************************************************
    // Helper functions: rate divider and span reciprocal
    // ****************************************************************
    function [15:0] rate_div;
        input [2:0] code;
        reg [31:0] dhz;
        reg [31:0] div;
        begin
            case (code)
                3'h0: dhz = `FPR_R0;
                3'h1: dhz = `FPR_R1;
                3'h2: dhz = `FPR_R2;
                3'h3: dhz = `FPR_R3;
                3'h4: dhz = `FPR_R4;
                3'h5: dhz = `FPR_R5;
                3'h6: dhz = `FPR_R6;
                default: dhz = `FPR_R7;
            endcase
            // Slowest rate still fits the 16-bit prescaler
            div = (`FPR_CLK_HZ * 10) / (dhz * `FPR_PWM_STEPS);
            rate_div = div[15:0];
        end
    endfunction

    function [9:0] span_rcp;
        input [3:0] code;
        begin
            case (code)
                4'h0: span_rcp = `FPR_RCP0;
                4'h1: span_rcp = `FPR_RCP1;
                4'h2: span_rcp = `FPR_RCP2;
                4'h3: span_rcp = `FPR_RCP3;
                4'h4: span_rcp = `FPR_RCP4;
                4'h5: span_rcp = `FPR_RCP5;
                4'h6: span_rcp = `FPR_RCP6;
                4'h7: span_rcp = `FPR_RCP7;
                4'h8: span_rcp = `FPR_RCP8;
                4'h9: span_rcp = `FPR_RCP9;
                4'hA: span_rcp = `FPR_RCPA;
                4'hB: span_rcp = `FPR_RCPB;
                4'hC: span_rcp = `FPR_RCPC;
                4'hD: span_rcp = `FPR_RCPD;
                4'hE: span_rcp = `FPR_RCPE;
                default: span_rcp = `FPR_RCPF;
            endcase
        end
    endfunction

    // ****************************************************************
    // Per-channel duty, overtemperature and PWM generation
    // ****************************************************************
    wire [7:0] target [0:2];
    wire [2:0] ot_hit;
    wire [2:0] pwm;
    wire [7:0] ramp_duty;

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
            wire [9:0] t = temp_in[ch*10 +: 10];
            wire [7:0] t_int = t[9:2];
            wire [7:0] lim = crit_limit_in[ch*8 +: 8];
            wire [7:0] st = fan_start_temp_in[ch*8 +: 8];
            wire [7:0] hy = hyst_in[ch*8 +: 8];
            wire [7:0] mn = min_duty_in[ch*8 +: 8];
            wire [7:0] cfg = cfg_q[ch];
            wire floor_en = ramp_q[`FPR_FLOOR_LSB + ch];
            wire [7:0] excess = (t_int > st) ? t_int - st : 8'h00;
            wire [7:0] head = 8'hFF - mn;
            wire [25:0] prod = excess * head *
                               span_rcp(cfg[`FPR_SPAN_LSB +: 4]);
            wire [15:0] inc = prod[`FPR_RCP_SHIFT +: 16];
            wire [16:0] sum = {9'h000, mn} + {1'b0, inc};
            reg run_q;
            reg ot_q;
            reg [7:0] duty_q;
            reg [15:0] pre_q;
            reg [7:0] ph_q;
            reg [7:0] tgt;

            // Fan starts above start temp, stops below start - hyst
            always @(posedge clk_in) begin
                if (!rst_n_in)
                    run_q <= 1'b0;
                else if (t_int > st)
                    run_q <= 1'b1;
                else if ({1'b0, t_int} + {1'b0, hy} < {1'b0, st})
                    run_q <= 1'b0;
            end

            // Auto target: floor below start, slope above
            always @* begin
                if (!auto_mode_in[ch])
                    tgt = manual_duty_in[ch*8 +: 8];
                else if (!run_q)
                    tgt = floor_en ? mn : 8'h00;
                else if (sum[16:8] != 9'h000)
                    tgt = 8'hFF;
                else
                    tgt = sum[7:0];
            end
            assign target[ch] = tgt;

            // Evaluated only at monitor ticks, so an assertion spans
            // at least one full monitoring cycle while its enable bit is left unchanged
            always @(posedge clk_in) begin
                if (!rst_n_in)
                    ot_q <= 1'b0;
                else if (monitor_cycle_in) begin
                    if (t > {lim, 2'b00})
                        ot_q <= 1'b1;
                    else
                        ot_q <= 1'b0;
                end
            end
            assign ot_hit[ch] = ot_q & cfg[`FPR_OT_BIT];

            // Status event on each new assertion by this channel
            reg hit_prev_q;
            always @(posedge clk_in) begin
                if (!rst_n_in)
                    hit_prev_q <= 1'b0;
                else
                    hit_prev_q <= ot_hit[ch];
            end
            assign evt[ch] = ot_hit[ch] & ~hit_prev_q;

            // Registered duty; channel 1 may come from the ramp
            always @(posedge clk_in) begin
                if (!rst_n_in)
                    duty_q <= 8'h00;
                else if (ch == 0)
                    duty_q <= ramp_duty;
                else
                    duty_q <= tgt;
            end

            // Prescaler then 256-step phase counter
            always @(posedge clk_in) begin
                if (!rst_n_in) begin
                    pre_q <= 16'h0000;
                    ph_q <= 8'h00;
                end else if (pre_q + 16'h0001 >=
                             rate_div(cfg[`FPR_RATE_LSB +: 3])) begin
                    pre_q <= 16'h0000;
                    ph_q <= ph_q + 8'h01;
                end else
                    pre_q <= pre_q + 16'h0001;
            end
            // Full scale holds the output high with no gap
            assign pwm[ch] = (duty_q == 8'hFF) | (ph_q < duty_q);
        end
    endgenerate

    assign fan_drive_out_1_out = pwm[0];
    assign fan_drive_out_2_out = pwm[1];
    assign fan_drive_out_3_out = pwm[2];

    // ****************************************************************
    // Overtemperature pin: open drain, driven low only
    // ****************************************************************
    reg pin_in_q;
    assign overtemp_pin_out = 1'b0;
    assign overtemp_pin_oe_out = |ot_hit;

    always @(posedge clk_in) begin
        if (!rst_n_in)
            pin_in_q <= 1'b1;
        else
            pin_in_q <= overtemp_pin_in;
    end

    // External low on the pin while not driving it; bits 0..2 come
    // from the channel loop
    assign evt[3] = pin_in_q & ~overtemp_pin_in & ~overtemp_pin_oe_out;

    // ****************************************************************
    // Channel 1 ramp: step size per slot from the ramp register
    // ****************************************************************
    reg [31:0] slot_q;
    reg [7:0] r_q;
    reg [7:0] step;
    wire slot_tick = (slot_q + 32'h0000_0001 >= RAMP_SLOT_CYCLES);
    wire ramp_on = ramp_q[`FPR_REN_BIT] & auto_mode_in[0];
    wire [8:0] up = {1'b0, r_q} + {1'b0, step};

    always @* begin
        case (ramp_q[`FPR_STEP_LSB +: 3])
            3'h0: step = 8'h01;
            3'h1: step = 8'h02;
            3'h2: step = 8'h03;
            3'h3: step = 8'h04;
            3'h4: step = 8'h08;
            3'h5: step = 8'h0C;
            3'h6: step = 8'h18;
            default: step = 8'h30;
        endcase
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            slot_q <= 32'h0000_0000;
            r_q <= 8'h00;
        end else begin
            slot_q <= slot_tick ? 32'h0000_0000 : slot_q + 32'h0000_0001;
            if (!ramp_on)
                r_q <= target[0];
            else if (slot_tick) begin
                // Never overshoot the target in either direction
                if (r_q < target[0])
                    r_q <= (up[7:0] > target[0] || up[8]) ?
                           target[0] : up[7:0];
                else if (r_q > target[0])
                    r_q <= (r_q - target[0] < step) ?
                           target[0] : r_q - step;
            end
        end
    end
    assign ramp_duty = r_q;

    // ****************************************************************
    // Speed-input grouping onto output 3
    // ****************************************************************
    // Grouped inputs are only sampled while output 3 is high, since
    // their fans are unpowered in its low phase
    assign speed_gate_out[0] = ramp_q[`FPR_GRP_BIT];
    assign speed_gate_out[1] = 1'b1;
    assign speed_gate_out[2] = 1'b1;
    assign speed_sample_out[0] = fan_speed_input_2_in &
        (~speed_gate_out[0] | pwm[2]);
    assign speed_sample_out[1] = fan_speed_input_3_in & pwm[2];
    assign speed_sample_out[2] = fan_speed_input_4_in & pwm[2];

endmodule // fpr_fan_ctrl

// ==== fpr_defines.vh ====
/*
 * Constants of the fan PWM slope and ramp block: register indices, field
 * positions, reset values, PWM rates, span reciprocals and ramp timing.
 * Included by fpr_fan_ctrl.v and by the bench; definitions only.
 */
//
// What this block does
// - 3-bit code picks PWM rate, default 35.3 Hz
// - Enabled channel at/above limit+0.25C drives pin low
// - Pin stays asserted until temperature at/below limit
// - Each pin assertion lasts one full monitoring cycle; here a mid-cycle enable-bit write starts or ends it at once
// - Enable bit zero: pin never driven, input only
// - 4-bit span code sets duty slope, default 32C
// - 3-bit code picks ramp step 1..48 per slot
// - Channel 1 duty ramps toward new target gradually
// - Ramping on channel 1 only when enable set
// - Grouping set: speed inputs 2,3,4 follow output 3
// - Grouping clear: only inputs 3,4 follow output 3
// - Channel 1 below start-hyst: zero or minimum duty
// - Channel 2 below start-hyst: zero or minimum duty
// - Channel 3 below start-hyst: zero or minimum duty
// - Ramp register resets zero, locked ignores writes
// - Config registers reset 0xC4, locked ignore writes
// - Above start: minimum duty, rising along span
`ifndef FPR_DEFINES_VH
`define FPR_DEFINES_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define FPR_IDX_CFG1 8'h5F
`define FPR_IDX_CFG2 8'h60
`define FPR_IDX_CFG3 8'h61
`define FPR_IDX_RAMP 8'h62
`define FPR_IDX_CTRL 8'h70
`define FPR_IDX_STAT 8'h71
`define FPR_IDX_MASK 8'h72

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define FPR_CFG_RST 8'hC4
`define FPR_RAMP_RST 8'h00
`define FPR_RATE_LSB 0
`define FPR_OT_BIT 3
`define FPR_SPAN_LSB 4
`define FPR_STEP_LSB 0
`define FPR_REN_BIT 3
`define FPR_GRP_BIT 4
`define FPR_FLOOR_LSB 5
`define FPR_LOCK_BIT 0
`define FPR_NSTAT 4

// ****************************************************************
// PWM rates in tenths of a hertz, 256 steps per PWM period
// ****************************************************************
`define FPR_CLK_HZ 10000000
`define FPR_PWM_STEPS 256
`define FPR_R0 110
`define FPR_R1 147
`define FPR_R2 221
`define FPR_R3 294
`define FPR_R4 353
`define FPR_R5 441
`define FPR_R6 588
`define FPR_R7 882

// ****************************************************************
// Span reciprocals, 1024 / span in degrees
// ****************************************************************
`define FPR_RCP_SHIFT 10
`define FPR_RCP0 10'd512
`define FPR_RCP1 10'd410
`define FPR_RCP2 10'd307
`define FPR_RCP3 10'd256
`define FPR_RCP4 10'd205
`define FPR_RCP5 10'd154
`define FPR_RCP6 10'd128
`define FPR_RCP7 10'd102
`define FPR_RCP8 10'd77
`define FPR_RCP9 10'd64
`define FPR_RCPA 10'd51
`define FPR_RCPB 10'd38
`define FPR_RCPC 10'd32
`define FPR_RCPD 10'd26
`define FPR_RCPE 10'd19
`define FPR_RCPF 10'd13

// ****************************************************************
// Ramp timing: 35 s for one count per slot over 171 duty counts
// ****************************************************************
`define FPR_RAMP_FULL_MS 35000
`define FPR_RAMP_COUNTS 171
`define FPR_CYC_PER_MS 10000

`endif

// ==== fpr_fan_ctrl_chk.sv ====
/* Checker for fpr_fan_ctrl: bus handshake and overtemp pin timing.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
module fpr_fan_ctrl_chk (
    input wire clk_in,
    input wire rst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    input wire irq_out,
    input wire monitor_cycle_in,
    input wire [29:0] temp_in,
    input wire [23:0] crit_limit_in,
    input wire overtemp_pin_out,
    input wire overtemp_pin_oe_out,
    input wire [2:0] speed_gate_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ****************************************
    // Channel heat seen at the last monitoring pulse
    // ****************************************
    wire [2:0] hot;
    wire [2:0] hot_seen_d;
    reg [2:0] hot_seen_q;
    // Quarter degrees against whole-degree limits
    assign hot[0] = temp_in[9:0] > {crit_limit_in[7:0], 2'h0};
    assign hot[1] = temp_in[19:10] > {crit_limit_in[15:8], 2'h0};
    assign hot[2] = temp_in[29:20] > {crit_limit_in[23:16], 2'h0};
    assign hot_seen_d = monitor_cycle_in ? hot : hot_seen_q;
    // Ignores the enable bits, so it only bounds the pin from above
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            hot_seen_q <= 3'h0;
        end else begin
            hot_seen_q <= hot_seen_d;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    AST_ACK_NEXT:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("no ack after a request");
    AST_ACK_PULSE:
    assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE:
    assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without a request");
    AST_DAT_UPPER:
    assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_PIN_LOW:
    assert property (overtemp_pin_oe_out |-> !overtemp_pin_out)
        else $error("pin driven high");
    AST_OE_CAUSE:
    assert property ($rose(overtemp_pin_oe_out) |-> hot_seen_q != 3'h0)
        else $error("pin asserted with no hot channel");
    AST_OE_RELEASE:
    assert property ((hot_seen_q == 3'h0) [*3] |-> !overtemp_pin_oe_out)
        else $error("pin held with every channel cool");
    AST_OE_MIN:
    assert property ($fell(overtemp_pin_oe_out) && $past(rst_n_in) |->
        $past(monitor_cycle_in) || $past(monitor_cycle_in, 2) ||
        $past(wb_ack_out) || $past(wb_ack_out, 2))
        else $error("pin released between monitoring pulses");
    AST_GATE_FIXED:
    assert property (speed_gate_out[2:1] == 2'h3)
        else $error("speed inputs 3 and 4 not grouped");
    COV_PIN: cover property ($rose(overtemp_pin_oe_out));
    COV_WRITE: cover property (wb_ack_out && wb_we_in);
    COV_IRQ: cover property ($rose(irq_out));
    COV_GROUP: cover property (speed_gate_out[0]);
endmodule // fpr_fan_ctrl_chk

bind fpr_fan_ctrl fpr_fan_ctrl_chk fpr_fan_ctrl_chk_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .irq_out(irq_out),
    .monitor_cycle_in(monitor_cycle_in), .temp_in(temp_in),
    .crit_limit_in(crit_limit_in), .overtemp_pin_out(overtemp_pin_out),
    .overtemp_pin_oe_out(overtemp_pin_oe_out),
    .speed_gate_out(speed_gate_out)
);

// ==== fpr_fan_model.sv ====
/* Behavioural cooling fan: turns while driven, gives a tach wave.
   Assumes one clock shared with the bench. */
`timescale 1ns/1ps
module fpr_fan_model #(
    parameter HALF = 8'h09
) (
    input wire clk_in,
    input wire drive_in,
    input wire stall_in,
    output reg tach_out
);
    // ************************
    // Rotor and tach sensor
    // ************************
    reg [7:0] spin_q = 8'h00;
    initial tach_out = 1'h1;
    // A stalled rotor leaves the tach line on its pull-up
    always @(posedge clk_in) begin
        if (stall_in) begin
            tach_out <= 1'h1;
        end else if (drive_in) begin
            spin_q <= (spin_q == HALF) ? 8'h00 : spin_q + 8'h01;
            if (spin_q == HALF) begin
                tach_out <= ~tach_out;
            end
        end
    end
endmodule // fpr_fan_model

// ==== testbench.sv ====
/* Self-checking bench for fpr_fan_ctrl with three fan models.
   Assumes fpr_defines.vh is on the include path. */
`timescale 1ns/1ps
`include "fpr_defines.vh"
module testbench;
    // ************************
    // Stimulus and wiring
    // ************************
    logic clk_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_adr = 32'h0;
    logic [31:0] wb_dat = 32'h0;
    logic mon = 1'h0;
    logic ext_low = 1'h0;
    logic [2:0] auto_mode = 3'h0;
    logic [2:0] stall = 3'h0;
    logic [23:0] crit = 24'h646464;
    logic [23:0] min_duty = 24'hFFFFFF;
    logic [29:0] temp = 30'h0;
    wire [31:0] rd_dat;
    wire wb_ack, irq, pin_drv, oe;
    wire [2:0] gate, samp, drv, tach;
    logic [2:0] seen;
    logic [7:0] rnd, lim1;
    logic [7:0] exp_q[$];
    int fails = 0;
    int n_compared = 0;
    // Pull-up on the pin: low while either side pulls it
    wire pin_lvl = oe ? pin_drv : ~ext_low;

    always #50 clk_in = ~clk_in;

    fpr_fan_ctrl #(.RAMP_SLOT_CYCLES(20)) fpr_fan_ctrl_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc),
        .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
        .wb_dat_in(wb_dat), .wb_sel_in(wb_sel), .wb_dat_out(rd_dat),
        .wb_ack_out(wb_ack), .irq_out(irq), .monitor_cycle_in(mon),
        .auto_mode_in(auto_mode), .manual_duty_in(24'h000000),
        .temp_in(temp), .crit_limit_in(crit),
        .fan_start_temp_in(24'h282828), .hyst_in(24'h040404),
        .min_duty_in(min_duty), .overtemp_pin_in(pin_lvl),
        .overtemp_pin_out(pin_drv), .overtemp_pin_oe_out(oe),
        .fan_speed_input_2_in(tach[0]), .fan_speed_input_3_in(tach[1]),
        .fan_speed_input_4_in(tach[2]), .speed_gate_out(gate),
        .speed_sample_out(samp), .fan_drive_out_1_out(drv[0]),
        .fan_drive_out_2_out(drv[1]), .fan_drive_out_3_out(drv[2])
    );
    // Fan 2 hangs on output 2, fans 3 and 4 share output 3
    fpr_fan_model fpr_fan_model_inst[2:0] (
        .clk_in(clk_in), .drive_in({drv[2], drv[2], drv[1]}),
        .stall_in(stall), .tach_out(tach)
    );
    // ************************
    // Tasks
    // ************************
    task chk(input logic [7:0] want, input logic [7:0] got);
        n_compared++;
        if (got !== want) begin
            fails++;
            $display("wrong value at %0t: want %h got %h", $time, want, got);
        end
    endtask
    // Classic cycle; a read notes its expected byte for the watcher.
    // Ack is read right after the edge, i.e. its sampled value.
    task bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_in);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= {22'h0, idx, 2'h0};
        wb_dat <= {24'h0, d};
        if (!we) exp_q.push_back(d);
        do @(posedge clk_in); while (wb_ack !== 1'h1);
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
    endtask
    // One monitoring pulse, then time for the pin to follow
    task pulse_mon;
        @(posedge clk_in);
        mon <= 1'h1;
        @(posedge clk_in);
        mon <= 1'h0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task check_resets;
        for (int i = 0; i < 3; i++) begin
            bus(1'h0, `FPR_IDX_CFG1 + i[7:0], `FPR_CFG_RST);
        end
        bus(1'h0, `FPR_IDX_RAMP, `FPR_RAMP_RST);
        bus(1'h0, `FPR_IDX_STAT, 8'h00);
        bus(1'h0, 8'h40, 8'h00);
        chk(8'h00, {6'h0, irq, oe});
    endtask
    task print_verdict;
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Takes the oldest note at the edge where read ack is sampled
    always @(posedge clk_in) begin
        if (wb_ack === 1'h1 && wb_we === 1'h0) begin
            if (exp_q.size() == 0) fails++;
            else chk(exp_q.pop_front(), rd_dat[7:0]);
        end
    end
    // Cuts a hang short
    initial begin
        repeat (40000) @(posedge clk_in);
        fails++;
        print_verdict();
    end
    // ************************
    // Scenarios
    // ************************
    initial begin
        rnd = 8'($urandom(32'hF5E7FF37));
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'h1;
        stall <= 3'($urandom);
        check_resets();
        rnd = 8'($urandom);
        bus(1'h1, `FPR_IDX_RAMP, rnd);
        bus(1'h0, `FPR_IDX_RAMP, rnd);
        rnd = 8'($urandom);
        bus(1'h1, `FPR_IDX_CFG2, rnd);
        bus(1'h0, `FPR_IDX_CFG2, rnd);
        bus(1'h1, 8'h40, 8'h5A);
        bus(1'h0, 8'h40, 8'h00);
        // Fans at rest keep tach high; output 3 is low here
        bus(1'h1, `FPR_IDX_RAMP, 8'h10);
        repeat (2) @(negedge clk_in);
        chk(8'h01, {4'h0, samp, gate[0]});
        bus(1'h1, `FPR_IDX_RAMP, 8'h00);
        repeat (2) @(negedge clk_in);
        chk(8'h02, {4'h0, samp, gate[0]});
        // Channel 1 a quarter degree over its limit, then exactly on it
        lim1 = 8'h20 + 8'($urandom % 64);
        crit[7:0] <= lim1;
        bus(1'h1, `FPR_IDX_MASK, 8'h01);
        bus(1'h1, `FPR_IDX_CFG2, 8'hC4);
        bus(1'h1, `FPR_IDX_CFG1, 8'hCC);
        temp[9:0] <= {lim1, 2'h0} + 10'h1;
        pulse_mon();
        chk(8'h03, {6'h0, irq, oe});
        @(posedge clk_in);
        temp[9:0] <= {lim1, 2'h0};
        repeat (8) @(negedge clk_in);
        chk(8'h01, {7'h0, oe});
        pulse_mon();
        chk(8'h00, {7'h0, oe});
        bus(1'h0, `FPR_IDX_STAT, 8'h01);
        bus(1'h0, `FPR_IDX_STAT, 8'h00);
        // Outside pull on the pin sets a masked status bit
        ext_low <= 1'h1;
        @(posedge clk_in);
        ext_low <= 1'h0;
        repeat (4) @(negedge clk_in);
        chk(8'h00, {7'h0, irq});
        bus(1'h0, `FPR_IDX_STAT, 8'h08);
        temp[19:10] <= 10'h3FF;
        pulse_mon();
        chk(8'h00, {7'h0, oe});
        bus(1'h1, `FPR_IDX_CFG2, 8'hCC);
        repeat (2) @(negedge clk_in);
        chk(8'h01, {7'h0, oe});
        temp <= 30'h0;
        pulse_mon();
        chk(8'h00, {7'h0, oe});
        // Automatic mode below start: floor bits pick off or minimum
        auto_mode <= 3'h7;
        bus(1'h1, `FPR_IDX_RAMP, 8'hA0);
        pulse_mon();
        seen = 3'h0;
        repeat (3000) begin
            @(negedge clk_in);
            seen = seen | drv;
        end
        chk(8'h05, {5'h0, seen});
        // Channel 1 falls from full one count per slot, then 48 per slot;
        // the PWM phase is still near zero, so high means duty above it
        bus(1'h1, `FPR_IDX_RAMP, 8'hA8);
        bus(1'h1, `FPR_IDX_RAMP, 8'h88);
        repeat (100) @(negedge clk_in);
        chk(8'h01, {7'h0, drv[0]});
        bus(1'h1, `FPR_IDX_RAMP, 8'h8F);
        repeat (200) @(negedge clk_in);
        chk(8'h00, {7'h0, drv[0]});
        // Locked registers ignore writes; a reset restores their reset values
        bus(1'h1, `FPR_IDX_CTRL, 8'h01);
        bus(1'h1, `FPR_IDX_RAMP, 8'h5A);
        bus(1'h0, `FPR_IDX_RAMP, 8'h8F);
        bus(1'h1, `FPR_IDX_CFG3, 8'h00);
        bus(1'h0, `FPR_IDX_CFG3, 8'hC4);
        @(posedge clk_in);
        rst_n_in <= 1'h0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'h1;
        check_resets();
        print_verdict();
    end
endmodule // testbench
